// *** pkg/iod_pkg.sv ***
package iod_pkg;

  // ==========================================================================
  // Geometry
  localparam int NUM_PORTS    = 4;
  localparam int PORT_ID_W    = 2;
  localparam int NUM_REGS     = 10;

  // ==========================================================================
  // Register offsets (byte addresses, one 32-bit word each)
  localparam logic [7:0] REG_CTRL      = 8'h00;  // Global control
  localparam logic [7:0] REG_STATUS    = 8'h04;  // Last routing result
  localparam logic [7:0] REG_CFG_ADDR  = 8'h08;  // config_address_reg shadow
  localparam logic [7:0] REG_COUNT     = 8'h0C;  // Requests decoded
  localparam logic [7:0] REG_PORT_BASE = 8'h10;  // Per port, stride 4

  // ==========================================================================
  // Per-port register fields
  localparam int F_IO_ON     = 0;   // port_io_access_on
  localparam int F_VID_ON    = 1;   // legacy_video_route_on
  localparam int F_VID_FULL  = 2;   // legacy_video_full_decode
  localparam int F_ISA_BLK   = 3;   // isa_alias_block_on
  localparam int F_BASE_LSB  = 8;   // io_window_base segment [11:8]
  localparam int F_TOP_LSB   = 12;  // io_window_top segment [15:12]
  localparam int F_BUS_LSB   = 16;  // Secondary bus number [23:16]
  localparam int F_SUB_LSB   = 24;  // Subordinate bus number [31:24]

  // Global control and config address fields
  localparam int F_CTRL_ON   = 0;   // Routing registers programmed
  localparam int F_CFG_ON    = 31;  // config_space_on_bit
  localparam int F_CFG_BUS   = 16;
  localparam int F_CFG_DEV   = 11;

  // ==========================================================================
  // Special I/O addresses
  localparam logic [15:0] IO_CFG_ADDR  = 16'h0CF8;
  localparam logic [15:0] IO_CFG_DATA  = 16'h0CFC;
  localparam logic [9:0]  VID_LO_A     = 10'h3B0;
  localparam logic [9:0]  VID_HI_A     = 10'h3BB;
  localparam logic [9:0]  VID_LO_B     = 10'h3C0;
  localparam logic [9:0]  VID_HI_B     = 10'h3DF;
  localparam logic [1:0]  ISA_LOW_QTR  = 2'h0;    // Bits [9:8] of usable range
  localparam logic [3:0]  SEG_SOUTH    = 4'h0;    // Lowest 4 KB segment
  localparam logic [11:0] MSG_ADDR_TOP = 12'hFEE; // Interrupt message window

  // ==========================================================================
  // Reset values
  localparam logic [31:0] RST_PORT     = 32'h0000_0000;
  localparam logic [31:0] RST_CFG_ADDR = 32'h0000_0000;

  // ==========================================================================
  // Routing result codes (status register [2:0])
  localparam logic [2:0] RES_SOUTH = 3'h1;
  localparam logic [2:0] RES_PORT  = 3'h2;
  localparam logic [2:0] RES_CFG   = 3'h3;
  localparam logic [2:0] RES_ABORT = 3'h4;
  localparam logic [2:0] RES_INTR  = 3'h5;
  localparam logic [2:0] RES_DONE  = 3'h6;  // Zero-length completion

  // Source encodings of a request
  localparam logic [2:0] SRC_CPU   = 3'h0;
  localparam logic [2:0] SRC_SOUTH = 3'h1;
  localparam logic [2:0] SRC_PORT0 = 3'h4;  // 4..7 = port 0..3

  // Decoder states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_DECODE = 3'b010,
    ST_ISSUE  = 3'b100
  } iod_state_type;

endpackage

// *** rtl/iod_decoder.sv ***
// Design decisions made here: the register offsets and the Wishbone slave port.
`timescale 1ns/100ps
// ============================================================================
// Overview of operation
// - Checks run in order VGA, config, ISA alias, window, default; first wins.
// - VGA enabled port takes accesses whose every byte lies in VGA ranges.
// - Low three address bits come from the eight byte enables.
// - DW to 0CF8h or 1-4 B to 0CFCh is config only when enable bit set.
// - Config accesses route by bus number in the address register; device number is only passed out.
// - ISA alias blocking sends upper 768 bytes of each 1 KB to south link.
// - Address within a port's base..limit window goes to that port.
// - Anything unmatched goes to the south link subtractively.
// - Inbound I/O is peer-to-peer only and decoded like processor I/O.
// - Inbound config-port I/O is routed as ordinary inbound I/O.
// - Inbound request decoded back to its own port is master aborted.
// - Zero-length config cycle to bridge completes in order without data.
// - I/O decode uses address bits 15 to 3, and bit 16 only to force south.
// - Accesses with bit 16 set decode as address zero, sent south.
// - Until routing registers are programmed every I/O access goes south.
// - Segment 0 to 0FFFh goes to the south link unless a VGA or config decode claims it.
// - Inbound writes to FEEx_xxxxh from south or port 0 become interrupt messages.
module iod_decoder (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Request
  input  wire logic        req_valid_i,
  input  wire logic        req_io_i,
  input  wire logic        req_write_i,
  input  wire logic        req_zero_len_i,
  input  wire logic [2:0]  req_src_i,
  input  wire logic [35:3] req_addr_i,
  input  wire logic [7:0]  req_be_i,
  // Result
  output logic             res_valid_o,
  output logic [1:0]       res_port_o,
  output logic             res_to_port_o,
  output logic             res_south_o,
  output logic             res_cfg_o,
  output logic [7:0]       res_cfg_bus_o,
  output logic [4:0]       res_cfg_dev_o,
  output logic             res_abort_o,
  output logic             res_intr_o,
  output logic             res_done_o,
  output logic             busy_o
);

  // ==========================================================================
  // Register file
  logic [31:0] words [iod_pkg::NUM_REGS];
  logic [31:0] rf_rdata;
  logic        wb_req;
  logic        rf_we;
  logic        rd_pend;
  logic [2:0]  last_res;
  logic [31:0] req_count;

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Words 0..3 are fixed-layout; words 4..7 per port
  assign rf_we  = wb_req && wb_we_i && wb_adr_i != iod_pkg::REG_STATUS
                  && wb_adr_i != iod_pkg::REG_COUNT && wb_adr_i[7:6] == 2'h0;

  iod_regfile u_rf (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .we_i    (rf_we),
    .waddr_i (wb_adr_i[5:2]),
    .wdata_i (wb_dat_i),
    .wsel_i  (wb_sel_i),
    .raddr_i (wb_adr_i[5:2]),
    .rdata_o (rf_rdata),
    .words_o (words)
  );

  // ==========================================================================
  // Bus answer: writes ack next edge, reads wait one more for memory data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      rd_pend  <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= 1'b0;
      if (wb_req && wb_we_i) begin
        wb_ack_o <= 1'b1;
        rd_pend  <= 1'b0;
      end else if (wb_req && !rd_pend) begin
        rd_pend <= 1'b1;
      end else if (wb_req && rd_pend) begin
        wb_ack_o <= 1'b1;
        rd_pend  <= 1'b0;
        // Status and counter live here, not in memory; unmapped reads zero
        if (wb_adr_i == iod_pkg::REG_STATUS) begin
          wb_dat_o <= {28'h0000000, busy_o, last_res};
        end else if (wb_adr_i == iod_pkg::REG_COUNT) begin
          wb_dat_o <= req_count;
        end else if (wb_adr_i[7:6] == 2'h0) begin
          wb_dat_o <= rf_rdata;
        end else begin
          wb_dat_o <= 32'h0000_0000;
        end
      end else begin
        rd_pend <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Address formation
  logic [15:0] a_start;
  logic [15:0] a_end;
  logic [2:0]  be_lo;
  logic [2:0]  be_hi;
  logic [3:0]  nbytes;

  // Low bits from byte enables; bit 16 dropped so it wraps to zero
  always_comb begin
    be_lo  = 3'h0;
    be_hi  = 3'h0;
    nbytes = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (req_be_i[i]) begin
        be_lo = 3'(i);
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (req_be_i[i]) begin
        be_hi  = 3'(i);
        nbytes = nbytes + 4'h1;
      end
    end
  end
  assign a_start = {req_addr_i[15:3], be_lo};
  assign a_end   = {req_addr_i[15:3], be_hi};

  // ==========================================================================
  // Per-port match terms
  logic [iod_pkg::NUM_PORTS-1:0] vid_hit;
  logic [iod_pkg::NUM_PORTS-1:0] win_hit;
  logic [iod_pkg::NUM_PORTS-1:0] isa_blk;
  logic [iod_pkg::NUM_PORTS-1:0] bus_hit;
  logic [31:0]                   cfg_addr;
  logic                          routing_on;

  assign cfg_addr   = words[2];
  assign routing_on = words[0][iod_pkg::F_CTRL_ON];

  function automatic logic in_vid(input logic [15:0] a, input logic full);
    logic ok;
    ok = (a[9:0] >= iod_pkg::VID_LO_A && a[9:0] <= iod_pkg::VID_HI_A)
         || (a[9:0] >= iod_pkg::VID_LO_B && a[9:0] <= iod_pkg::VID_HI_B);
    return ok && (!full || a[15:10] == 6'h00);
  endfunction

  genvar gp;
  generate
    for (gp = 0; gp < iod_pkg::NUM_PORTS; gp++) begin : g_port
      logic [31:0] pr;
      assign pr = words[4 + gp];
      // Both end bytes checked; range is contiguous inside one 1 KB block
      assign vid_hit[gp] = pr[iod_pkg::F_IO_ON] && pr[iod_pkg::F_VID_ON]
                           && in_vid(a_start, pr[iod_pkg::F_VID_FULL])
                           && in_vid(a_end, pr[iod_pkg::F_VID_FULL]);
      assign win_hit[gp] = pr[iod_pkg::F_IO_ON]
                           && a_start[15:12] >= pr[iod_pkg::F_BASE_LSB +: 4]
                           && a_start[15:12] <= pr[iod_pkg::F_TOP_LSB +: 4];
      assign isa_blk[gp] = win_hit[gp] && pr[iod_pkg::F_ISA_BLK]
                           && a_start[9:8] != iod_pkg::ISA_LOW_QTR;
      assign bus_hit[gp] = cfg_addr[iod_pkg::F_CFG_BUS +: 8] >= pr[iod_pkg::F_BUS_LSB +: 8]
                           && cfg_addr[iod_pkg::F_CFG_BUS +: 8] <= pr[iod_pkg::F_SUB_LSB +: 8];
    end
  endgenerate

  // ==========================================================================
  // Priority decode
  logic       inbound;
  logic       cfg_port;
  logic [2:0] next_res;
  logic [1:0] next_port;

  assign inbound  = req_src_i != iod_pkg::SRC_CPU;
  // Inbound I/O never forms a config cycle
  assign cfg_port = req_io_i && !inbound && cfg_addr[iod_pkg::F_CFG_ON]
                    && ((a_start == iod_pkg::IO_CFG_ADDR && nbytes == 4'h4)
                     || (a_start[15:2] == iod_pkg::IO_CFG_DATA[15:2] && nbytes != 4'h0));

  always_comb begin
    next_res  = iod_pkg::RES_SOUTH;
    next_port = 2'h0;
    if (!req_io_i) begin
      // Memory path: only interrupt messages and zero-length cycles handled here
      if (req_zero_len_i && !inbound) begin
        next_res = iod_pkg::RES_DONE;
      end else if (req_write_i && req_addr_i[35:20] == {4'h0, iod_pkg::MSG_ADDR_TOP}
                   && (req_src_i == iod_pkg::SRC_SOUTH || req_src_i == iod_pkg::SRC_PORT0)) begin
        next_res = iod_pkg::RES_INTR;
      end
    end else if (!routing_on || req_addr_i[16]) begin
      // Bit 16 is the wrap past the top of I/O space, which lands at zero
      next_res = iod_pkg::RES_SOUTH;
    end else if (req_zero_len_i && cfg_port) begin
      next_res = iod_pkg::RES_DONE;
    end else begin
      // Same decode for processor and peer traffic; segment 0 never opens a window
      for (int p = iod_pkg::NUM_PORTS - 1; p >= 0; p--) begin
        if (win_hit[p] && !isa_blk[p] && a_start[15:12] != iod_pkg::SEG_SOUTH
            && next_res == iod_pkg::RES_SOUTH) begin
          next_res  = iod_pkg::RES_PORT;
          next_port = 2'(p);
        end
      end
      for (int p = iod_pkg::NUM_PORTS - 1; p >= 0; p--) begin
        if (isa_blk[p]) begin
          next_res = iod_pkg::RES_SOUTH;
        end
      end
      if (cfg_port) begin
        next_res = iod_pkg::RES_CFG;
        for (int p = iod_pkg::NUM_PORTS - 1; p >= 0; p--) begin
          if (bus_hit[p]) begin
            next_port = 2'(p);
          end
        end
      end
      for (int p = iod_pkg::NUM_PORTS - 1; p >= 0; p--) begin
        if (vid_hit[p]) begin
          next_res  = iod_pkg::RES_PORT;
          next_port = 2'(p);
        end
      end
    end
    if (req_src_i[2] && next_res == iod_pkg::RES_PORT && next_port == req_src_i[1:0]) begin
      next_res = iod_pkg::RES_ABORT;
    end
  end

  // ==========================================================================
  // Sequencer: capture decoded result in idle, skip ST_DECODE, issue one result pulse
  iod_pkg::iod_state_type state;
  logic [2:0] hold_res;
  logic [1:0] hold_port;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state     <= iod_pkg::ST_IDLE;
      hold_res  <= iod_pkg::RES_SOUTH;
      hold_port <= 2'h0;
      busy_o    <= 1'b0;
    end else begin
      unique case (state)
        iod_pkg::ST_IDLE: begin
          if (req_valid_i) begin
            hold_res  <= next_res;
            hold_port <= next_port;
            busy_o    <= 1'b1;
            state     <= iod_pkg::ST_ISSUE;
          end
        end
        iod_pkg::ST_DECODE: begin
          state <= iod_pkg::ST_ISSUE;
        end
        iod_pkg::ST_ISSUE: begin
          busy_o <= 1'b0;
          state  <= iod_pkg::ST_IDLE;
        end
        default: begin
          state <= iod_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Result flags, mutually exclusive one-cycle pulses beside res_valid_o; port, bus and device registered every cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      res_valid_o   <= 1'b0;
      res_port_o    <= 2'h0;
      res_to_port_o <= 1'b0;
      res_south_o   <= 1'b0;
      res_cfg_o     <= 1'b0;
      res_cfg_bus_o <= 8'h00;
      res_cfg_dev_o <= 5'h00;
      res_abort_o   <= 1'b0;
      res_intr_o    <= 1'b0;
      res_done_o    <= 1'b0;
      last_res      <= 3'h0;
      req_count     <= 32'h0000_0000;
    end else begin
      res_valid_o   <= state == iod_pkg::ST_ISSUE;
      res_port_o    <= hold_port;
      res_to_port_o <= state == iod_pkg::ST_ISSUE && hold_res == iod_pkg::RES_PORT;
      res_south_o   <= state == iod_pkg::ST_ISSUE && hold_res == iod_pkg::RES_SOUTH;
      res_cfg_o     <= state == iod_pkg::ST_ISSUE && hold_res == iod_pkg::RES_CFG;
      res_abort_o   <= state == iod_pkg::ST_ISSUE && hold_res == iod_pkg::RES_ABORT;
      res_intr_o    <= state == iod_pkg::ST_ISSUE && hold_res == iod_pkg::RES_INTR;
      res_done_o    <= state == iod_pkg::ST_ISSUE && hold_res == iod_pkg::RES_DONE;
      res_cfg_bus_o <= cfg_addr[iod_pkg::F_CFG_BUS +: 8];
      res_cfg_dev_o <= cfg_addr[iod_pkg::F_CFG_DEV +: 5];
      if (state == iod_pkg::ST_ISSUE) begin
        last_res  <= hold_res;
        req_count <= req_count + 32'h0000_0001;
      end
    end
  end

  // ==========================================================================
  // Checks
  a_south_default: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == iod_pkg::ST_IDLE && req_valid_i && req_io_i && !routing_on)
      |-> ##2 res_south_o)
    else $error("I/O not sent south while routing is off");

  a_seg_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == iod_pkg::ST_IDLE && req_valid_i && req_io_i && a_start[15:12] == 4'h0
     && !cfg_port && !(|vid_hit))
      |-> ##2 (res_south_o && !res_to_port_o))
    else $error("Segment zero not routed south");

  a_one_hot_res: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot0({res_to_port_o, res_south_o, res_cfg_o, res_abort_o, res_intr_o, res_done_o}))
    else $error("Routing results not exclusive");

  a_self_abort: assert property (@(posedge clk_i) disable iff (rst_i)
    res_to_port_o |-> $past(req_src_i, 2) != {1'b1, res_port_o} || !$past(req_valid_i, 2))
    else $error("Inbound routed to its own port");

  a_inb_no_cfg: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == iod_pkg::ST_IDLE && req_valid_i && inbound) |-> ##2 !res_cfg_o)
    else $error("Inbound I/O serviced as config");

  a_cfg_needs_on: assert property (@(posedge clk_i) disable iff (rst_i)
    res_cfg_o |-> $past(cfg_addr[iod_pkg::F_CFG_ON], 2))
    else $error("Config access with enable bit clear");

  a_valid_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    res_valid_o |=> !res_valid_o)
    else $error("Result valid longer than one cycle");

  a_intr_fwd: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == iod_pkg::ST_IDLE && req_valid_i && !req_io_i && req_write_i && !req_zero_len_i
     && req_src_i == iod_pkg::SRC_SOUTH && req_addr_i[35:20] == 16'h0FEE) |-> ##2 res_intr_o)
    else $error("Interrupt message not forwarded");

endmodule

// *** rtl/iod_regfile.sv ***
`timescale 1ns/100ps
// ============================================================================
// Small register memory: one word per entry, registered read data
module iod_regfile (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Write port
  input  wire logic        we_i,
  input  wire logic [3:0]  waddr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wsel_i,
  // Read port
  input  wire logic [3:0]  raddr_i,
  output logic      [31:0] rdata_o,
  // All words, for the decoder
  output logic      [31:0] words_o [iod_pkg::NUM_REGS]
);

  logic [31:0] mem [iod_pkg::NUM_REGS];

  // Byte-lane writes, cleared on reset
  genvar gi;
  generate
    for (gi = 0; gi < iod_pkg::NUM_REGS; gi++) begin : g_word
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          mem[gi] <= iod_pkg::RST_PORT;
        end else if (we_i && waddr_i == 4'(gi)) begin
          for (int b = 0; b < 4; b++) begin
            if (wsel_i[b]) begin
              mem[gi][b*8 +: 8] <= wdata_i[b*8 +: 8];
            end
          end
        end
      end
      assign words_o[gi] = mem[gi];
    end
  endgenerate

  // Registered read, out-of-range reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (raddr_i < 4'(iod_pkg::NUM_REGS)) begin
      rdata_o <= mem[raddr_i];
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

endmodule

// *** tb/iod_req_model.sv ***
`timescale 1ns/100ps
// ============================================================================
// Requester on the far side: cpu, south link or a peer port
module iod_req_model (
  // Clock
  input  wire logic        clk_i,
  // Decoder handshake
  input  wire logic        busy_i,
  input  wire logic        res_valid_i,
  input  wire logic [5:0]  res_flags_i,
  input  wire logic [1:0]  res_port_i,
  // Request
  output logic             req_valid_o,
  output logic             req_io_o,
  output logic             req_write_o,
  output logic             req_zero_len_o,
  output logic [2:0]       req_src_o,
  output logic [35:3]      req_addr_o,
  output logic [7:0]       req_be_o
);
  // Idle values at time zero
  initial begin
    req_valid_o = 1'b0;
    req_io_o = 1'b0;
    req_write_o = 1'b0;
    req_zero_len_o = 1'b0;
    req_src_o = 3'h0;
    req_addr_o = '0;
    req_be_o = 8'h00;
  end

  // One request; code 7 flags more or fewer than one result line
  task automatic issue(input logic [2:0] src, input logic io, input logic zl, input logic wr,
                       input logic [35:0] a, input logic [7:0] be,
                       output logic [2:0] code, output logic [1:0] port);
    integer n;
    begin
      code = 3'h0;
      port = 2'h0;
      n = 0;
      @(posedge clk_i);
      #1;
      while (busy_i !== 1'b0 && n < 20) begin
        @(posedge clk_i);
        #1;
        n++;
      end
      @(posedge clk_i);
      req_valid_o <= 1'b1;
      req_io_o <= io;
      req_write_o <= wr;
      req_zero_len_o <= zl;
      req_src_o <= src;
      req_addr_o <= a[35:3];
      req_be_o <= be;
      @(posedge clk_i);
      // Released lines show the inverse, so a stale sample cannot pass
      req_valid_o <= 1'b0;
      req_addr_o <= ~a[35:3];
      req_be_o <= ~be;
      for (n = 0; n < 8; n++) begin
        @(posedge clk_i);
        #1;
        if (res_valid_i === 1'b1) begin
          code = ($countones(res_flags_i) == 1) ? 3'($clog2(res_flags_i) + 1) : 3'h7;
          port = res_port_i;
          break;
        end
      end
    end
  endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/100ps
// ============================================================================
// Decoder bench: Wishbone set-up, then routed requests
module testbench;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        req_valid_i, req_io_i, req_write_i, req_zero_len_i;
  logic [2:0]  req_src_i;
  logic [35:3] req_addr_i;
  logic [7:0]  req_be_i;
  logic        res_valid_o, res_to_port_o, res_south_o, res_cfg_o, res_abort_o, res_intr_o, res_done_o, busy_o;
  logic [1:0]  res_port_o;
  logic [7:0]  res_cfg_bus_o;
  logic [4:0]  res_cfg_dev_o;
  logic [31:0] rd;
  integer      n_errors = 0;
  integer      cmp_count = 0;

  always #25 clk_i = ~clk_i;

  iod_decoder iod_decoder_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .req_valid_i(req_valid_i), .req_io_i(req_io_i), .req_write_i(req_write_i),
    .req_zero_len_i(req_zero_len_i), .req_src_i(req_src_i), .req_addr_i(req_addr_i), .req_be_i(req_be_i),
    .res_valid_o(res_valid_o), .res_port_o(res_port_o), .res_to_port_o(res_to_port_o),
    .res_south_o(res_south_o), .res_cfg_o(res_cfg_o), .res_cfg_bus_o(res_cfg_bus_o),
    .res_cfg_dev_o(res_cfg_dev_o), .res_abort_o(res_abort_o), .res_intr_o(res_intr_o),
    .res_done_o(res_done_o), .busy_o(busy_o));

  iod_req_model iod_req_model_inst (.clk_i(clk_i), .busy_i(busy_o), .res_valid_i(res_valid_o),
    .res_flags_i({res_done_o, res_intr_o, res_abort_o, res_cfg_o, res_to_port_o, res_south_o}),
    .res_port_i(res_port_o), .req_valid_o(req_valid_i), .req_io_o(req_io_i), .req_write_o(req_write_i),
    .req_zero_len_o(req_zero_len_i), .req_src_o(req_src_i), .req_addr_o(req_addr_i), .req_be_o(req_be_i));

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Classic single cycle; write lands and read data is taken at the ack edge
  task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d);
    integer n;
    begin
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      n = 0;
      do begin
        @(posedge clk_i);
        n++;
      end while (wb_ack_o !== 1'b1 && n < 10);
      if (n >= 10) check("wb ack", 32'h0, 32'h1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
    end
  endtask

  // Request with expected result code, and port where one applies
  task automatic rq(input logic [2:0] src, input logic io, input logic zl, input logic [35:0] a,
                    input logic [7:0] be, input logic [2:0] ec, input logic [1:0] ep);
    logic [2:0] code;
    logic [1:0] port;
    begin
      // Memory requests go out as writes, I/O requests as reads
      iod_req_model_inst.issue(src, io, zl, !io, a, be, code, port);
      check("result code", 32'(code), 32'(ec));
      if (ec == iod_pkg::RES_PORT || ec == iod_pkg::RES_CFG) check("result port", 32'(port), 32'(ep));
    end
  endtask

  // Verdict, the one exit of the run
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Watchdog, well past the few hundred cycles the tests need
  initial begin
    #400000;
    n_errors++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values and the unmapped hole
    wb_cycle(1'b0, 8'h10, 32'h0);
    check("port0 reg", rd, iod_pkg::RST_PORT);
    wb_cycle(1'b0, 8'h08, 32'h0);
    check("cfg addr reg", rd, iod_pkg::RST_CFG_ADDR);
    wb_cycle(1'b1, 8'h40, 32'hFFFF_FFFF);
    wb_cycle(1'b0, 8'h40, 32'h0);
    check("unmapped", rd, 32'h0);
    // Contiguous segments: port0 seg 1..2 with video, port1 seg 3 with alias block, port2 seg 0
    wb_cycle(1'b1, 8'h10, 32'h0000_2103);
    wb_cycle(1'b1, 8'h14, 32'h0605_3309);
    wb_cycle(1'b1, 8'h18, 32'h0000_0001);
    rq(iod_pkg::SRC_CPU, 1'b1, 1'b0, 36'h1004, 8'h10, iod_pkg::RES_SOUTH, 2'h0);
    wb_cycle(1'b1, 8'h00, 32'h0000_0001);
    rq(iod_pkg::SRC_CPU, 1'b1, 1'b0, 36'h1004, 8'h10, iod_pkg::RES_PORT, 2'h0);
    rq(iod_pkg::SRC_CPU, 1'b1, 1'b0, 36'h2FF8, 8'h80, iod_pkg::RES_PORT, 2'h0);
    rq(iod_pkg::SRC_CPU, 1'b1, 1'b0, 36'h33C0, 8'h01, iod_pkg::RES_PORT, 2'h0);
    rq(iod_pkg::SRC_CPU, 1'b1, 1'b0, 36'h53B8, 8'h08, iod_pkg::RES_PORT, 2'h0);
    rq(iod_pkg::SRC_CPU, 1'b1, 1'b0, 36'h53B8, 8'h18, iod_pkg::RES_SOUTH, 2'h0);
    rq(iod_pkg::SRC_CPU, 1'b1, 1'b0, 36'h3100, 8'h01, iod_pkg::RES_SOUTH, 2'h0);
    rq(iod_pkg::SRC_CPU, 1'b1, 1'b0, 36'h3004, 8'h10, iod_pkg::RES_PORT, 2'h1);
    rq(iod_pkg::SRC_CPU, 1'b1, 1'b0, 36'h4000, 8'h01, iod_pkg::RES_SOUTH, 2'h0);
    rq(iod_pkg::SRC_CPU, 1'b1, 1'b0, 36'h0100, 8'h01, iod_pkg::RES_SOUTH, 2'h0);
    rq(iod_pkg::SRC_CPU, 1'b1, 1'b0, 36'h11004, 8'h10, iod_pkg::RES_SOUTH, 2'h0);
    rq(iod_pkg::SRC_CPU, 1'b1, 1'b0, 36'h1_0000_1004, 8'h10, iod_pkg::RES_PORT, 2'h0);
    // Full video decode on port 0: only the true low block matches
    wb_cycle(1'b1, 8'h10, 32'h0000_2107);
    rq(iod_pkg::SRC_CPU, 1'b1, 1'b0, 36'h53B8, 8'h08, iod_pkg::RES_SOUTH, 2'h0);
    rq(iod_pkg::SRC_CPU, 1'b1, 1'b0, 36'h03B8, 8'h08, iod_pkg::RES_PORT, 2'h0);
    // Config port protocol, disabled then enabled for bus 5 device 3
    wb_cycle(1'b1, 8'h08, 32'h0005_1800);
    rq(iod_pkg::SRC_CPU, 1'b1, 1'b0, 36'h0CF8, 8'h10, iod_pkg::RES_SOUTH, 2'h0);
    wb_cycle(1'b1, 8'h08, 32'h8005_1800);
    check("cfg bus", 32'(res_cfg_bus_o), 32'h05);
    check("cfg dev", 32'(res_cfg_dev_o), 32'h03);
    rq(iod_pkg::SRC_CPU, 1'b1, 1'b0, 36'h0CF8, 8'h10, iod_pkg::RES_CFG, 2'h1);
    rq(iod_pkg::SRC_CPU, 1'b1, 1'b0, 36'h0CF8, 8'h0F, iod_pkg::RES_CFG, 2'h1);
    rq(iod_pkg::SRC_CPU, 1'b1, 1'b0, 36'h0CF8, 8'h03, iod_pkg::RES_SOUTH, 2'h0);
    rq(iod_pkg::SRC_CPU, 1'b1, 1'b1, 36'h0CF8, 8'h10, iod_pkg::RES_DONE, 2'h0);
    // Inbound peers, and memory writes to the interrupt window from cpu, port 0 and south link
    rq(iod_pkg::SRC_PORT0, 1'b1, 1'b0, 36'h0CF8, 8'h10, iod_pkg::RES_SOUTH, 2'h0);
    rq(iod_pkg::SRC_PORT0, 1'b1, 1'b0, 36'h3004, 8'h10, iod_pkg::RES_PORT, 2'h1);
    rq(iod_pkg::SRC_PORT0 + 3'h1, 1'b1, 1'b0, 36'h3004, 8'h10, iod_pkg::RES_ABORT, 2'h0);
    rq(iod_pkg::SRC_CPU, 1'b0, 1'b0, 36'hFEE0_0000, 8'h0F, iod_pkg::RES_SOUTH, 2'h0);
    rq(iod_pkg::SRC_PORT0, 1'b0, 1'b0, 36'hFEE0_1000, 8'h0F, iod_pkg::RES_INTR, 2'h0);
    rq(iod_pkg::SRC_SOUTH, 1'b0, 1'b0, 36'hFEE0_0000, 8'h0F, iod_pkg::RES_INTR, 2'h0);
    // Status is read-only and keeps the last result
    wb_cycle(1'b1, 8'h04, 32'h0000_0000);
    wb_cycle(1'b0, 8'h04, 32'h0);
    check("status", {28'h0, rd[3:0]}, 32'(iod_pkg::RES_INTR));
    test_done();
  end
endmodule
